//--- hw/rts_sequencer.sv
// reset cause tracking and time-out sequencing with an ahb-lite slave
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
`include "rts_defs.svh"

// How it works
// [R1] seven reset kinds are told apart and reported
// [R2] watchdog wake from sleep resumes without a reset-state load
// [R3] scratch word is never reset, kept across all resets
// [R4] the external reset pin is input only, never driven
// [R5] external reset lows shorter than minimum width are ignored
// [R6] supply-settle timer runs on rc ticks about 72 ms holding reset
// [R7] then 1024 oscillator input edges are counted before release
// [R8] oscillator count only in crystal modes, on power-on or wake
// [R9] supply low for the brown-out time while enabled resets device
// [R10] after brown-out wait for supply, then a full settle period
// [R11] supply dip during settle clears timer and restarts brown-out
// [R12] brown-out enable forces the settle timer on
// [R13] power-on runs settle first, then oscillator count, then release
// [R14] rc mode without settle timer, or rc wake, has no delay
// [R15] pin held low past time-outs: run starts as pin rises
// [R16] brown-out flag set by software, cleared by brown-out reset
// [R17] power-on flag cleared by power-on only
// [R18] power-on sets expiry and sleep-entry flags
// [R19] expiry and sleep-entry flags follow the reset kind table
// [R20] settle enable configuration bit is active low
// [R21] brown-out enable configuration bit is active high
// [R22] oscillator select 11 rc, 10 fast, 01 standard, 00 low power
// [R23] pin is synchronised and qualified by a programmable width
module rts_sequencer #(
  parameter int unsigned P_RC_DIV       = `RTS_RC_DIV_CYCLES,
  parameter int unsigned P_SETTLE_TICKS = `RTS_SETTLE_TICKS
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // pins and detectors (asynchronous)
  input  wire logic        i_ext_reset_n,
  input  wire logic        i_supply_ok,
  input  wire logic        i_osc_in,
  // core side (same clock)
  input  wire logic        i_watchdog_expire,
  input  wire logic        i_sleep,
  input  wire logic        i_wake_irq,
  // configuration bits
  input  wire logic        i_supply_settle_enable_n,
  input  wire logic        i_brownout_enable,
  input  wire logic [1:0]  i_osc_select,
  // sequencer outputs
  output logic             o_core_hold,
  output logic             o_load_reset,
  output logic             o_resume,
  output logic      [2:0]  o_reset_kind
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  rts_pkg::rts_state_t state_q, state_d;
  rts_pkg::rts_kind_t  kind_q;
  rts_pkg::rts_reg_t   wr_sel_q, rd_sel_q;
  logic        wr_pend_q, rd_pend_q;
  logic        hready_q, hresp_q;
  logic [31:0] hrdata_q;
  logic [7:0]  pin_min_q;
  logic [31:0] scratch_q;
  logic        expiry_q, sleep_q, por_q, bor_q;
  logic        hold_q, load_q, resume_q;
  logic        pin_lvl_n, pin_act, vdd_ok_s, vdd_low_act;
  logic        osc_s1_q, osc_s2_q, osc_s3_q, osc_edge;
  logic [15:0] rc_div_q, settle_cnt_q;
  logic [9:0]  osc_cnt_q;
  logic        rc_tick, settle_done, osc_done;
  logic        settle_en, bor_en, crystal;
  logic        bor_evt, pin_evt, wdt_evt, irq_evt, addr_ok;

  ////////////////////////////////////////////////////////////////////////
  // configuration decode

  assign bor_en    = i_brownout_enable;                // [R21]
  assign settle_en = !i_supply_settle_enable_n || bor_en; // [R20] [R12]
  assign crystal   = i_osc_select != `RTS_OSC_RC;     // [R22]

  // offset decode, shared by read and write paths
  function automatic rts_pkg::rts_reg_t rts_decode(input logic [7:0] a);
    if (a == `RTS_OFF_STATUS)       rts_decode = rts_pkg::RTS_R_STATUS;
    else if (a == `RTS_OFF_POWER_CONTROL_STATUS)    rts_decode = rts_pkg::RTS_R_POWER_CONTROL_STATUS;
    else if (a == `RTS_OFF_CTRL)    rts_decode = rts_pkg::RTS_R_CTRL;
    else if (a == `RTS_OFF_STATE)   rts_decode = rts_pkg::RTS_R_STATE;
    else if (a == `RTS_OFF_SCRATCH) rts_decode = rts_pkg::RTS_R_SCRATCH;
    else                            rts_decode = rts_pkg::RTS_R_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // input qualification

  // pin is sampled only; no output path exists toward it
  rts_glitch_filter u_pin_filter (             // [R4] [R23]
    .i_clock     (i_clock),
    .i_nrst      (i_nrst),
    .i_line_n    (i_ext_reset_n),
    .i_min_width ({8'h00, pin_min_q}),          // [R5]
    .o_level_n_q (pin_lvl_n),
    .o_act_q     (pin_act)
  );

  // supply low must last the brown-out time before it trips
  rts_glitch_filter u_vdd_filter (
    .i_clock     (i_clock),
    .i_nrst      (i_nrst),
    .i_line_n    (i_supply_ok),
    .i_min_width (16'(`RTS_BOR_MIN_CYCLES - 1)), // [R9]
    .o_level_n_q (vdd_ok_s),
    .o_act_q     (vdd_low_act)
  );

  // oscillator input: two sync flops, third for edge detect
  // limitation: oscillator must run below half the system clock
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= i_osc_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end
  assign osc_edge = osc_s2_q && !osc_s3_q;

  ////////////////////////////////////////////////////////////////////////
  // timers

  // free-running rc tick, stands in for the internal rc oscillator
  always_ff @(posedge i_clock) begin
    if (!i_nrst || rc_tick) rc_div_q <= 16'h0000;
    else                    rc_div_q <= rc_div_q + 16'h0001;
  end
  assign rc_tick = rc_div_q == 16'(P_RC_DIV - 1);

  // settle timer cleared whenever it is not running
  always_ff @(posedge i_clock) begin
    if (!i_nrst || state_q != rts_pkg::RTS_SETTLE) begin
      settle_cnt_q <= 16'h0000;                       // [R11]
    end else if (rc_tick) begin
      settle_cnt_q <= settle_cnt_q + 16'h0001;        // [R6]
    end
  end
  assign settle_done = rc_tick
                    && settle_cnt_q == 16'(P_SETTLE_TICKS - 1);

  // oscillator settle edge counter
  always_ff @(posedge i_clock) begin
    if (!i_nrst || state_q != rts_pkg::RTS_OSC) begin
      osc_cnt_q <= 10'h000;
    end else if (osc_edge) begin
      osc_cnt_q <= osc_cnt_q + 10'h001;               // [R7]
    end
  end
  assign osc_done = osc_edge
                 && osc_cnt_q == 10'(`RTS_OSC_SETTLE_EDGES - 1);

  ////////////////////////////////////////////////////////////////////////
  // reset events, brown-out first, then pin, then watchdog

  assign bor_evt = bor_en && vdd_low_act                // [R9]
                && state_q != rts_pkg::RTS_BOR_LOW
                && state_q != rts_pkg::RTS_POR;
  assign pin_evt = !bor_evt && pin_act && state_q == rts_pkg::RTS_RUN;
  assign wdt_evt = !bor_evt && !pin_evt && i_watchdog_expire
                && state_q == rts_pkg::RTS_RUN;
  assign irq_evt = !bor_evt && !pin_evt && !wdt_evt && i_wake_irq
                && i_sleep && state_q == rts_pkg::RTS_RUN;

  ////////////////////////////////////////////////////////////////////////
  // sequencer state machine

  always_comb begin
    state_d = state_q;
    case (state_q)
      rts_pkg::RTS_POR: begin                           // [R13]
        if (settle_en)    state_d = rts_pkg::RTS_SETTLE;
        else if (crystal) state_d = rts_pkg::RTS_OSC;  // [R8]
        else              state_d = rts_pkg::RTS_HOLD; // [R14]
      end
      rts_pkg::RTS_SETTLE: begin
        if (bor_en && !vdd_ok_s) state_d = rts_pkg::RTS_BOR_LOW; // [R11]
        else if (settle_done) begin
          if (crystal && kind_q == rts_pkg::RTS_K_POR)
            state_d = rts_pkg::RTS_OSC;                 // [R8]
          else
            state_d = rts_pkg::RTS_HOLD;
        end
      end
      rts_pkg::RTS_OSC: begin
        if (osc_done) state_d = rts_pkg::RTS_HOLD;
      end
      rts_pkg::RTS_BOR_LOW: begin
        if (vdd_ok_s) state_d = rts_pkg::RTS_SETTLE;  // [R10] [R12]
      end
      rts_pkg::RTS_HOLD: begin
        if (!pin_act) state_d = rts_pkg::RTS_RUN;     // [R15]
      end
      default: begin
        if (wdt_evt && i_sleep) begin                 // [R2]
          state_d = crystal ? rts_pkg::RTS_OSC : rts_pkg::RTS_RUN; // [R14]
        end else if (irq_evt) begin
          state_d = crystal ? rts_pkg::RTS_OSC : rts_pkg::RTS_RUN;
        end else if (pin_evt || wdt_evt) begin
          state_d = rts_pkg::RTS_HOLD;
        end
      end
    endcase
    if (bor_evt) state_d = rts_pkg::RTS_BOR_LOW;       // [R10]
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) state_q <= rts_pkg::RTS_POR;
    else         state_q <= state_d;
  end

  // reset kind record
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      kind_q <= rts_pkg::RTS_K_POR;                     // [R1]
    end else if (bor_evt) begin
      kind_q <= rts_pkg::RTS_K_BOR;
    end else if (pin_evt) begin
      kind_q <= i_sleep ? rts_pkg::RTS_K_PIN_SLEEP : rts_pkg::RTS_K_PIN_RUN;
    end else if (wdt_evt) begin
      kind_q <= i_sleep ? rts_pkg::RTS_K_WDT_WAKE : rts_pkg::RTS_K_WDT;
    end else if (irq_evt) begin
      kind_q <= rts_pkg::RTS_K_IRQ_WAKE;
    end
  end

  // outputs registered from next state so they align with state_q
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      hold_q   <= 1'b1;
      load_q   <= 1'b1;
      resume_q <= 1'b0;
    end else begin
      hold_q   <= state_d != rts_pkg::RTS_RUN;
      load_q   <= bor_evt || pin_evt || (wdt_evt && !i_sleep); // [R2]
      // rc wake stays in run, so it still needs its own resume pulse
      resume_q <= (state_d == rts_pkg::RTS_RUN
               && state_q != rts_pkg::RTS_RUN)
               || (((wdt_evt && i_sleep) || irq_evt) && !crystal); // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cause flags; hardware updates are applied after the software write

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      expiry_q <= 1'b1;                                 // [R18]
      sleep_q  <= 1'b1;
      por_q    <= 1'b0;                                 // [R17]
      bor_q    <= 1'b0;
    end else begin
      if (wr_pend_q && wr_sel_q == rts_pkg::RTS_R_POWER_CONTROL_STATUS) begin
        por_q <= i_hwdata[`RTS_BIT_POR];
        bor_q <= i_hwdata[`RTS_BIT_BOR];               // [R16]
      end
      if (bor_evt) begin                                // [R19]
        expiry_q <= 1'b1;
        sleep_q  <= 1'b1;
        bor_q    <= 1'b0;                               // [R16]
      end else if (wdt_evt) begin
        expiry_q <= 1'b0;
        sleep_q  <= !i_sleep;
      end else if (irq_evt || (pin_evt && i_sleep)) begin
        expiry_q <= 1'b1;
        sleep_q  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: writes zero-wait, reads one wait state

  assign addr_ok = i_hsel && i_hready && i_htrans[`RTS_HTRANS_ACT];

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_sel_q  <= rts_pkg::RTS_R_NONE;
      rd_sel_q  <= rts_pkg::RTS_R_NONE;
      hready_q  <= 1'b1;
      hresp_q   <= 1'b0;
    end else begin
      wr_pend_q <= addr_ok && i_hwrite;
      rd_pend_q <= addr_ok && !i_hwrite;
      hready_q  <= !(addr_ok && !i_hwrite);
      if (addr_ok) begin
        wr_sel_q <= rts_decode(i_haddr[7:0]);
        rd_sel_q <= rts_decode(i_haddr[7:0]);
      end
    end
  end

  // read mux one cycle late so a preceding write is already visible
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      hrdata_q <= 32'h0000_0000;
      if (rd_sel_q == rts_pkg::RTS_R_STATUS) begin
        hrdata_q[`RTS_BIT_EXPIRY] <= expiry_q;
        hrdata_q[`RTS_BIT_SLEEP]  <= sleep_q;
      end else if (rd_sel_q == rts_pkg::RTS_R_POWER_CONTROL_STATUS) begin
        hrdata_q[`RTS_BIT_POR] <= por_q;
        hrdata_q[`RTS_BIT_BOR] <= bor_q;
      end else if (rd_sel_q == rts_pkg::RTS_R_CTRL) begin
        hrdata_q[7:0] <= pin_min_q;
      end else if (rd_sel_q == rts_pkg::RTS_R_STATE) begin
        hrdata_q[6:0] <= {hold_q, kind_q, state_q};
      end else if (rd_sel_q == rts_pkg::RTS_R_SCRATCH) begin
        hrdata_q <= scratch_q;
      end
    end
  end

  // pin qualifying width, software steered
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      pin_min_q <= `RTS_PIN_MIN_DEF;
    end else if (wr_pend_q && wr_sel_q == rts_pkg::RTS_R_CTRL) begin
      pin_min_q <= i_hwdata[7:0];                      // [R23]
    end
  end

  // survives every reset; unknown until first written
  always_ff @(posedge i_clock) begin
    if (wr_pend_q && wr_sel_q == rts_pkg::RTS_R_SCRATCH) begin
      scratch_q <= i_hwdata;                           // [R3]
    end
  end

  assign o_hrdata     = hrdata_q;
  assign o_hreadyout  = hready_q;
  assign o_hresp      = hresp_q;
  assign o_core_hold  = hold_q;
  assign o_load_reset = load_q;
  assign o_resume     = resume_q;
  assign o_reset_kind = kind_q;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  AST_WAKE_NO_LOAD: assert property ( // [R2]
    wdt_evt && i_sleep |=> !o_load_reset ##1 !o_load_reset)
    else $error("watchdog wake loaded reset state");
  AST_POR_FLAGS: assert property ( // [R18]
    state_q == rts_pkg::RTS_POR |-> expiry_q && sleep_q && !por_q)
    else $error("power-on flags wrong");
  AST_SETTLE_HOLD: assert property ( // [R6]
    state_q == rts_pkg::RTS_SETTLE |-> o_core_hold)
    else $error("core released during settle");
  AST_OSC_LAST: assert property ( // [R7]
    state_q == rts_pkg::RTS_OSC && !osc_done && !bor_evt
      |=> state_q == rts_pkg::RTS_OSC)
    else $error("oscillator count left early");
  AST_NO_OSC_RC: assert property ( // [R8]
    !crystal && state_q != rts_pkg::RTS_OSC
      |=> state_q != rts_pkg::RTS_OSC)
    else $error("oscillator count in rc mode");
  AST_BOR_RESTART: assert property ( // [R11]
    state_q == rts_pkg::RTS_SETTLE && bor_en && !vdd_ok_s
      |=> state_q == rts_pkg::RTS_BOR_LOW ##1 settle_cnt_q == 16'h0000)
    else $error("settle not restarted on supply dip");
  AST_BOR_STAY: assert property ( // [R10]
    state_q == rts_pkg::RTS_BOR_LOW && !vdd_ok_s
      |=> state_q == rts_pkg::RTS_BOR_LOW && o_core_hold)
    else $error("left brown-out with supply low");
  AST_PIN_RELEASE: assert property ( // [R15]
    state_q == rts_pkg::RTS_HOLD && !pin_act |=> !o_core_hold && o_resume)
    else $error("run not started on pin release");
  AST_WDT_FLAGS: assert property ( // [R19]
    wdt_evt && !i_sleep |=> !expiry_q && sleep_q && o_load_reset)
    else $error("watchdog reset flags wrong");
  AST_BOR_FLAG: assert property ( // [R16]
    bor_evt |=> !bor_q && expiry_q && sleep_q)
    else $error("brown-out flag not cleared");

  COV_BOR_SEQ: cover property (
    state_q == rts_pkg::RTS_BOR_LOW ##1 state_q == rts_pkg::RTS_SETTLE);
  COV_WDT_WAKE: cover property (wdt_evt && i_sleep);
  COV_PIN_RESET: cover property (pin_evt ##1 state_q == rts_pkg::RTS_HOLD);

endmodule

//--- hw/rts_defs.svh
// constants for the reset timeout sequencer
`ifndef RTS_DEFS_SVH
`define RTS_DEFS_SVH

// timing, each time in its own unit
`define RTS_CLK_PERIOD_NS    100
`define RTS_SETTLE_TIME_US   72000
`define RTS_RC_PERIOD_NS     100000
`define RTS_BOR_MIN_TIME_NS  100000
`define RTS_RC_DIV_CYCLES    (`RTS_RC_PERIOD_NS / `RTS_CLK_PERIOD_NS)
`define RTS_SETTLE_TICKS     ((`RTS_SETTLE_TIME_US * 1000) / `RTS_RC_PERIOD_NS)
`define RTS_BOR_MIN_CYCLES   ((`RTS_BOR_MIN_TIME_NS + `RTS_CLK_PERIOD_NS - 1) / `RTS_CLK_PERIOD_NS)
`define RTS_OSC_SETTLE_EDGES 1024

// register offsets (byte addresses)
`define RTS_OFF_STATUS  8'h00
`define RTS_OFF_POWER_CONTROL_STATUS    8'h04
`define RTS_OFF_CTRL    8'h08
`define RTS_OFF_STATE   8'h0c
`define RTS_OFF_SCRATCH 8'h10

// field positions
`define RTS_BIT_EXPIRY  4
`define RTS_BIT_SLEEP   3
`define RTS_BIT_POR     1
`define RTS_BIT_BOR     0

// reset values and encodings
`define RTS_PIN_MIN_DEF 8'h0a
`define RTS_OSC_RC      2'h3
`define RTS_HTRANS_ACT  1

`endif

//--- hw/rts_pkg.sv
// types shared by the reset timeout sequencer
package rts_pkg;

  typedef enum logic [2:0] {
    RTS_POR, RTS_SETTLE, RTS_OSC, RTS_BOR_LOW, RTS_HOLD, RTS_RUN
  } rts_state_t;

  typedef enum logic [2:0] {
    RTS_K_POR, RTS_K_PIN_RUN, RTS_K_PIN_SLEEP, RTS_K_WDT,
    RTS_K_WDT_WAKE, RTS_K_BOR, RTS_K_IRQ_WAKE
  } rts_kind_t;

  typedef enum logic [2:0] {
    RTS_R_STATUS, RTS_R_POWER_CONTROL_STATUS, RTS_R_CTRL, RTS_R_STATE, RTS_R_SCRATCH,
    RTS_R_NONE
  } rts_reg_t;

endpackage

//--- hw/rts_glitch_filter.sv
// two-flop synchroniser plus minimum-low-width qualifier
`timescale 1ns/1ns
module rts_glitch_filter (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // raw active-low line and qualifying width
  input  wire logic        i_line_n,
  input  wire logic [15:0] i_min_width,
  // synced level and qualified low
  output logic             o_level_n_q,
  output logic             o_act_q
);

  logic        s1_q;
  logic [15:0] cnt_q;

  // s1 feeds only the second flop
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      s1_q        <= 1'b1;
      o_level_n_q <= 1'b1;
    end else begin
      s1_q        <= i_line_n;
      o_level_n_q <= s1_q;
    end
  end

  // short lows never reach the counter threshold
  always_ff @(posedge i_clock) begin
    if (!i_nrst || o_level_n_q) begin
      cnt_q   <= 16'h0000;
      o_act_q <= 1'b0;
    end else begin
      if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h0001;
      if (cnt_q >= i_min_width) o_act_q <= 1'b1;
    end
  end

endmodule

//--- verif/rts_far_side.sv
// far-side model: reset pin driver, supply monitor and crystal input
`timescale 1ns/1ns
module rts_far_side (
  // requests from the bench
  input  wire logic i_pin_low,
  input  wire logic i_supply_low,
  input  wire logic i_osc_on,
  // pins toward the sequencer
  output logic      o_ext_reset_n,
  output logic      o_supply_ok,
  output logic      o_osc_in
);
  // pin has a pull-up, so a released pin reads high
  assign o_ext_reset_n = ~i_pin_low;
  // monitor reads high while the supply is above the threshold
  assign o_supply_ok = ~i_supply_low;
  // 290 ns period: under 5 MHz and drifting against the system clock
  initial o_osc_in = 1'b0;
  always begin
    #145;
    if (i_osc_on) begin
      o_osc_in = ~o_osc_in;
    end
  end
endmodule

//--- verif/tb.sv
// self-checking bench for the reset timeout sequencer
`timescale 1ns/1ns
`include "rts_defs.svh"
module tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        pin_low = 1'b0;
  logic        sup_low = 1'b0;
  logic        osc_on = 1'b1;
  logic        pin_n;
  logic        sup_ok;
  logic        osc;
  logic        wdog = 1'b0;
  logic        sleep = 1'b0;
  logic        irq = 1'b0;
  logic        sn = 1'b0;
  logic        be = 1'b0;
  logic [1:0]  osel = 2'h2;
  logic        hold;
  logic        load;
  logic        resume;
  logic [2:0]  kind;
  logic        seen_load = 1'b0;
  logic [31:0] rd;
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc;
  // config {osel, settle_n, bor_en} and release window per power-on
  logic [3:0]  cfg [6] = '{4'hc, 4'hf, 4'h8, 4'h6, 4'h2, 4'he};
  int          lo [6] = '{16, 16, 2975, 2955, 2955, 1};
  int          hi [6] = '{30, 30, 3100, 3060, 3060, 6};
  // event {sleep, act, load, kind, status} with act 0 pin 1 wdt 2 irq
  logic [15:0] ev [5] = '{16'h0918, 16'h1b08, 16'h8a10, 16'h9400,
                          16'ha610};

  // 10 MHz system clock
  always #50 clk = ~clk;

  // catch the one-cycle reset-state load pulse
  always @(posedge clk) if (load === 1'b1) seen_load <= 1'b1;

  rts_sequencer #(.P_RC_DIV(4), .P_SETTLE_TICKS(5)) u_rts_sequencer (
    .i_clock                  (clk),
    .i_nrst                   (nrst),
    .i_hsel                   (hsel),
    .i_haddr                  (haddr),
    .i_htrans                 (htrans),
    .i_hwrite                 (hwrite),
    .i_hsize                  (3'h2),
    .i_hready                 (hready),
    .i_hwdata                 (hwdata),
    .o_hrdata                 (hrdata),
    .o_hreadyout              (hready),
    .o_hresp                  (hresp),
    .i_ext_reset_n            (pin_n),
    .i_supply_ok              (sup_ok),
    .i_osc_in                 (osc),
    .i_watchdog_expire        (wdog),
    .i_sleep                  (sleep),
    .i_wake_irq               (irq),
    .i_supply_settle_enable_n (sn),
    .i_brownout_enable        (be),
    .i_osc_select             (osel),
    .o_core_hold              (hold),
    .o_load_reset             (load),
    .o_resume                 (resume),
    .o_reset_kind             (kind)
  );

  rts_far_side u_rts_far_side (
    .i_pin_low     (pin_low),
    .i_supply_low  (sup_low),
    .i_osc_on      (osc_on),
    .o_ext_reset_n (pin_n),
    .o_supply_ok   (sup_ok),
    .o_osc_in      (osc)
  );

  ////////////////////////////////////////////////////////////
  // verdict, comparisons and bounded waits
  task automatic close_out();
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic rng(input int l, input int h);
    check_count++;
    if (cyc < l || cyc > h) begin
      $display("BAD t=%0t got=%h exp=%h", $time, cyc, l);
      miscompares++;
    end
  endtask

  // r=1 waits for resume, r=0 for hready; a hang ends the run
  task automatic wait_on(input logic r, input int lim);
    cyc = 0;
    do begin
      @(posedge clk);
      cyc++;
    end while ((r ? resume : hready) !== 1'b1 && cyc < lim);
    if (cyc >= lim) begin
      miscompares++;
      close_out();
    end
  endtask

  // single ahb-lite transfer; read data lands in rd
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_on(1'b0, 40);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_on(1'b0, 40);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [31:0] a, m, e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  // power-on with a config; reset held 6 cycles, then wait release
  task automatic power_on(input logic [3:0] c);
    nrst   <= 1'b0;
    osel   <= c[3:2];
    sn     <= c[1];
    be     <= c[0];
    osc_on <= (c[3:2] != 2'h3);
    repeat (6) @(posedge clk);
    chk({hold, load, resume, kind}, 32'h30);
    nrst <= 1'b1;
    wait_on(1'b1, 4000);
  endtask

  // one reset or wake event, run until the core resumes
  task automatic event_run(input logic s, input logic [1:0] a);
    seen_load <= 1'b0;
    sleep     <= s;
    @(posedge clk);
    if (a == 2'h0) begin
      pin_low <= 1'b1;
      repeat (30) @(posedge clk);
      chk(hold, 1'b1);
      pin_low <= 1'b0;
    end else begin
      wdog <= a[0];
      irq  <= a[1];
      @(posedge clk);
      wdog <= 1'b0;
      irq  <= 1'b0;
    end
    wait_on(1'b1, 60);
    sleep <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence; power-on sweep ends in rc mode with settle off and bor off, bor is turned on last
  initial begin
    for (int i = 0; i < 6; i++) begin
      power_on(cfg[i]);
      rng(lo[i], hi[i]);
      chk(kind, 3'h0);
    end
    rchk(`RTS_OFF_STATUS, 32'h18, 32'h18);
    rchk(`RTS_OFF_POWER_CONTROL_STATUS, 32'hffffffff, 32'h0);
    bus(1'b1, `RTS_OFF_POWER_CONTROL_STATUS, 32'h3);
    rchk(`RTS_OFF_POWER_CONTROL_STATUS, 32'hffffffff, 32'h3);
    bus(1'b1, `RTS_OFF_SCRATCH, 32'h5a5a1234);
    bus(1'b1, 32'h20, 32'hffffffff);
    rchk(32'h20, 32'hffffffff, 32'h0);
    rchk(`RTS_OFF_CTRL, 32'hff, 32'h0a);
    chk(hresp, 1'b0);
    // glitch shorter than the qualifying width
    seen_load <= 1'b0;
    pin_low   <= 1'b1;
    repeat (5) @(posedge clk);
    pin_low <= 1'b0;
    repeat (20) @(posedge clk);
    chk({hold, seen_load}, 2'b00);
    for (int i = 0; i < 5; i++) begin
      event_run(ev[i][15], ev[i][13:12]);
      rng(1, 8);
      chk({seen_load, kind}, ev[i][11:8]);
      rchk(`RTS_OFF_STATUS, 32'h18, ev[i][7:0]);
    end
    rchk(`RTS_OFF_POWER_CONTROL_STATUS, 32'hffffffff, 32'h3);
    // brown-out, then a second dip inside the settle period
    be        <= 1'b1;
    seen_load <= 1'b0;
    sup_low   <= 1'b1;
    repeat (1100) @(posedge clk);
    chk({hold, kind}, 4'hd);
    sup_low <= 1'b0;
    repeat (8) @(posedge clk);
    sup_low <= 1'b1;
    repeat (30) @(posedge clk);
    chk(hold, 1'b1);
    repeat (980) @(posedge clk);
    sup_low <= 1'b0;
    wait_on(1'b1, 100);
    rng(16, 30);
    chk(seen_load, 1'b1);
    rchk(`RTS_OFF_STATUS, 32'h18, 32'h18);
    rchk(`RTS_OFF_POWER_CONTROL_STATUS, 32'hffffffff, 32'h2);
    rchk(`RTS_OFF_SCRATCH, 32'hffffffff, 32'h5a5a1234);
    close_out();
  end
endmodule
